/* vecirq_cpu_model.sv */
/*
 vecirq_cpu_model: behavioural cpu taking vectored interrupts.
 assumes: level-high request line with the vector valid beside it;
 the bench drives the global interrupt enable.
*/
`timescale 1ns/10ps
module vecirq_cpu_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic gie_in,
   input wire logic irq_in,
   input wire logic [7:0] vector_in,
   output logic taken_out,
   output logic [7:0] taken_vec_out
);
   logic busy_q;
   // acknowledge blocks further takes until software drops the enable
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         taken_out <= 1'b0;
         taken_vec_out <= 8'h00;
      end else begin
         taken_out <= 1'b0;
         if (!gie_in) begin
            busy_q <= 1'b0;
         end else if (irq_in && !busy_q) begin
            busy_q <= 1'b1;
            taken_out <= 1'b1;
            taken_vec_out <= vector_in;
         end
      end
   end
endmodule : vecirq_cpu_model

/* vecirq_pkg.sv */
/*
 vecirq_pkg: register map, field layout, reset values and sizes for
 the vectored interrupt unit.
 assumes: a 32-bit AHB-Lite slave port with word-aligned registers.
*/
package vecirq_pkg;
   localparam int VECIRQ_NSRC = 16;
   localparam int VECIRQ_NEXT = 4;
   localparam int VECIRQ_IDXW = 4;
   localparam int VECIRQ_AW = 8;
   // byte offsets of the register file
   localparam logic [7:0] VECIRQ_OFS_VECTOR = 8'h00;
   localparam logic [7:0] VECIRQ_OFS_ENABLE = 8'h04;
   localparam logic [7:0] VECIRQ_OFS_PENDING = 8'h08;
   localparam logic [7:0] VECIRQ_OFS_ECLR = 8'h0c;
   localparam logic [7:0] VECIRQ_OFS_KIND = 8'h10;
   localparam logic [7:0] VECIRQ_OFS_POL = 8'h14;
   localparam logic [7:0] VECIRQ_OFS_SEL = 8'h18;
   // source select register bits
   localparam int VECIRQ_SEL_SCAN = 0;
   localparam int VECIRQ_SEL_DMA0 = 1;
   localparam int VECIRQ_SEL_PIS = 2;
   localparam int VECIRQ_SEL_W = 3;
   // request positions with a selectable source, and the serial-wire position
   localparam int VECIRQ_SRC_SCANSEL = 11;
   localparam int VECIRQ_SRC_DMA0SEL = 13;
   localparam int VECIRQ_SRC_PISSEL = 14;
   localparam int VECIRQ_SRC_SERIAL = 0;
   // external pin positions
   localparam int VECIRQ_EXT_A = 1;
   localparam int VECIRQ_EXT_B = 4;
   localparam int VECIRQ_EXT_C = 9;
   localparam int VECIRQ_EXT_D = 15;
   // vector upper nibble pattern
   localparam logic [3:0] VECIRQ_VEC_HI = 4'h2;
   localparam logic [15:0] VECIRQ_RST16 = 16'h0000;
   localparam logic [2:0] VECIRQ_RST_SEL = 3'h0;
   localparam logic [1:0] VECIRQ_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] VECIRQ_HSIZE_WORD = 3'h2;
endpackage : vecirq_pkg

/* vecirq_sync.sv */
/*
 vecirq_sync: three-stage synchroniser for asynchronous request pins;
 the output changes only when stages two and three agree.
 assumes: one clock, asynchronous active-high reset, clock enable.
*/
`timescale 1ns/10ps
module vecirq_sync
   import vecirq_pkg::*;
#(
   parameter int W = 4
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce_in) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // only accept a level both later stages agree on
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_agree
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               sync_out[g] <= 1'b0;
            end else if (ce_in && (s2_q[g] == s3_q[g])) begin
               sync_out[g] <= s3_q[g];
            end
         end
      end
   endgenerate
endmodule : vecirq_sync

/* vecirq_unit.sv */
/*
 vecirq_unit: sixteen-source vectored interrupt controller with an
 AHB-Lite register port and an interrupt line to the cpu.
 assumes: internal sources are synchronous to clk_in; external pins
 are asynchronous; single-word AHB transfers only.
*/
// Design decisions made here: the address map and the AHB-Lite register port.
// Operation
// - sixteen requests, fixed priority, request 15 highest, request 0 lowest
// - enable mask bit n set enables request n
// - read-only pending shows every pending request, enabled or not
// - edge requests stay latched after the source goes inactive
// - level requests follow the source and clear when it goes inactive
// - write one to edge clear bit clears an edge request; else no effect
// - trigger kind bit zero is level, one is edge
// - polarity zero low/falling, one high/rising
// - vectors always lie in 20 to 2f hex, one per source
// - vector register upper nibble 0010, low nibble highest enabled pending
// - interrupt output active when any request is pending and enabled
// - requests 11, 13, 14 sources picked by scanner, dma0, printer bits
// - external pins synchronised before detection
// - no nesting limit; only mask and cpu enable govern nesting
// - serial-wire request on source 0 is high while that interface idles
`timescale 1ns/10ps
module vecirq_unit
   import vecirq_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // internal sources
   input wire logic serial_wire_idle_in,
   input wire logic tick_in,
   input wire logic timer_in,
   input wire logic uart_in,
   input wire logic codec_tx_in,
   input wire logic codec_rx_in,
   input wire logic codec_err_in,
   input wire logic printer_motor_in,
   input wire logic scanner_motor_in,
   input wire logic dma2_in,
   input wire logic dma3_in,
   input wire logic scanner_in,
   input wire logic dma0_in,
   input wire logic printer_in,
   input wire logic dma1_in,
   // external pins
   input wire logic external_request_a_in,
   input wire logic external_request_b_in,
   input wire logic external_request_c_in,
   input wire logic external_request_d_in,
   // cpu side
   output logic cpu_interrupt_request_out,
   output logic [7:0] interrupt_vector_out
);
   logic [15:0] interrupt_enable_mask_q;
   logic [15:0] trigger_kind_select_q;
   logic [15:0] trigger_polarity_select_q;
   logic [VECIRQ_SEL_W-1:0] module_configuration_q;
   logic [15:0] interrupt_pending_q;
   logic [15:0] interrupt_pending_d;
   logic [15:0] raw_src;
   logic [15:0] prev_src_q;
   logic [15:0] active_lvl;
   logic [15:0] edge_hit;
   logic [15:0] eclr_pulse;
   logic [15:0] req_live;
   logic [3:0] ext_sync;
   logic [3:0] vector_index_field;
   logic any_req;
   logic [7:0] vector_q;
   logic irq_q;
   // ahb data-phase capture
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic [31:0] rdata_q;
   logic take;

   // picks highest set bit; shared by vector and checks
   function automatic logic [3:0] vecirq_top(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < VECIRQ_NSRC; i++) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : vecirq_top

   vecirq_sync #(
      .W(VECIRQ_NEXT)
   ) u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .async_in({external_request_d_in, external_request_c_in,
                 external_request_b_in, external_request_a_in}),
      .sync_out(ext_sync)
   );

   // source wiring
   always_comb begin
      raw_src = '0;
      raw_src[VECIRQ_SRC_SERIAL] = serial_wire_idle_in;
      raw_src[VECIRQ_EXT_A] = ext_sync[0];
      raw_src[2] = tick_in;
      raw_src[3] = timer_in;
      raw_src[VECIRQ_EXT_B] = ext_sync[1];
      raw_src[5] = uart_in;
      raw_src[6] = codec_tx_in;
      raw_src[7] = codec_rx_in;
      raw_src[8] = codec_err_in;
      raw_src[VECIRQ_EXT_C] = ext_sync[2];
      raw_src[10] = printer_motor_in;
      raw_src[VECIRQ_SRC_SCANSEL] = module_configuration_q[VECIRQ_SEL_SCAN] ?
         scanner_motor_in : dma2_in;
      raw_src[12] = dma3_in;
      raw_src[VECIRQ_SRC_DMA0SEL] = module_configuration_q[VECIRQ_SEL_DMA0] ?
         scanner_in : dma0_in;
      raw_src[VECIRQ_SRC_PISSEL] = module_configuration_q[VECIRQ_SEL_PIS] ?
         printer_in : dma1_in;
      raw_src[VECIRQ_EXT_D] = ext_sync[3];
   end

   // polarity folds every source into active-high
   assign active_lvl = raw_src ~^ trigger_polarity_select_q;
   // edge = inactive last cycle, active now
   assign edge_hit = active_lvl & ~(prev_src_q ~^ trigger_polarity_select_q);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_src_q <= VECIRQ_RST16;
      end else if (ce_in) begin
         prev_src_q <= raw_src;
      end
   end

   // pending: edge latched with set over clear, level follows
   always_comb begin
      for (int i = 0; i < VECIRQ_NSRC; i++) begin
         if (trigger_kind_select_q[i]) begin
            interrupt_pending_d[i] = edge_hit[i] |
               (interrupt_pending_q[i] & ~eclr_pulse[i]);
         end else begin
            interrupt_pending_d[i] = active_lvl[i];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         interrupt_pending_q <= VECIRQ_RST16;
      end else if (ce_in) begin
         interrupt_pending_q <= interrupt_pending_d;
      end
   end

   // nesting is purely software via the mask
   assign req_live = interrupt_pending_q & interrupt_enable_mask_q;
   assign any_req = |req_live;
   assign vector_index_field = any_req ? vecirq_top(req_live) : 4'h0;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_q <= 1'b0;
         vector_q <= {VECIRQ_VEC_HI, 4'h0};
      end else if (ce_in) begin
         irq_q <= any_req;
         vector_q <= {VECIRQ_VEC_HI, vector_index_field};
      end
   end

   assign cpu_interrupt_request_out = irq_q;
   assign interrupt_vector_out = vector_q;

   // ahb-lite slave: zero wait states, always okay
   assign take = hsel_in && hready_in && htrans_in[1];
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (ce_in) begin
         wr_pend_q <= take && hwrite_in;
         rd_pend_q <= take && !hwrite_in;
         if (take) begin
            addr_q <= haddr_in[VECIRQ_AW-1:0];
         end
      end
   end

   // edge clear acts in the write data phase only
   assign eclr_pulse = (ce_in && wr_pend_q && addr_q == VECIRQ_OFS_ECLR) ?
      hwdata_in[15:0] : 16'h0000;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         interrupt_enable_mask_q <= VECIRQ_RST16;
         trigger_kind_select_q <= VECIRQ_RST16;
         trigger_polarity_select_q <= VECIRQ_RST16;
         module_configuration_q <= VECIRQ_RST_SEL;
      end else if (ce_in && wr_pend_q) begin
         unique case (addr_q)
            VECIRQ_OFS_ENABLE: interrupt_enable_mask_q <= hwdata_in[15:0];
            VECIRQ_OFS_KIND: trigger_kind_select_q <= hwdata_in[15:0];
            VECIRQ_OFS_POL: trigger_polarity_select_q <= hwdata_in[15:0];
            VECIRQ_OFS_SEL: module_configuration_q <= hwdata_in[VECIRQ_SEL_W-1:0];
            default: ;
         endcase
      end
   end

   // read data registered at the address phase, live at data phase
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce_in && take && !hwrite_in) begin
         unique case (haddr_in[VECIRQ_AW-1:0])
            VECIRQ_OFS_VECTOR: rdata_q <= {24'h000000, VECIRQ_VEC_HI,
               vector_index_field};
            VECIRQ_OFS_ENABLE: rdata_q <= {16'h0000, interrupt_enable_mask_q};
            VECIRQ_OFS_PENDING: rdata_q <= {16'h0000, interrupt_pending_q};
            VECIRQ_OFS_KIND: rdata_q <= {16'h0000, trigger_kind_select_q};
            VECIRQ_OFS_POL: rdata_q <= {16'h0000, trigger_polarity_select_q};
            VECIRQ_OFS_SEL: rdata_q <= {29'h00000000, module_configuration_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign hrdata_out = rd_pend_q ? rdata_q : 32'h0000_0000;

   // checks
   property p_irq_follows;
      @(posedge clk_in) disable iff (rst_in)
      ce_in |=> (cpu_interrupt_request_out == $past(|req_live));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq line mismatch");

   property p_vec_range;
      @(posedge clk_in) disable iff (rst_in)
      interrupt_vector_out[7:4] == VECIRQ_VEC_HI;
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector out of range");

   property p_vec_idle;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !any_req) |=> (interrupt_vector_out[3:0] == 4'h0 && !cpu_interrupt_request_out);
   endproperty
   a_vec_idle: assert property (p_vec_idle) else $error("idle vector not zero");

   property p_vec_top;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && any_req) |=> (interrupt_vector_out[3:0] == vecirq_top($past(req_live)));
   endproperty
   a_vec_top: assert property (p_vec_top) else $error("vector not highest");

   property p_edge_hold;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && trigger_kind_select_q[3] && interrupt_pending_q[3] && !eclr_pulse[3])
         |=> interrupt_pending_q[3];
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("edge pending lost");

   property p_edge_clear;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && trigger_kind_select_q[2] && eclr_pulse[2] && !edge_hit[2])
         |=> !interrupt_pending_q[2];
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge clear ignored");

   property p_level;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !trigger_kind_select_q[5]) |=> (interrupt_pending_q[5] == $past(active_lvl[5]));
   endproperty
   a_level: assert property (p_level) else $error("level pending wrong");

   property p_edge_set;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && trigger_kind_select_q[10] && edge_hit[10]) |=> interrupt_pending_q[10];
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("edge not latched");

   property p_sel11;
      @(posedge clk_in) disable iff (rst_in)
      module_configuration_q[VECIRQ_SEL_SCAN] |-> (raw_src[11] == scanner_motor_in);
   endproperty
   a_sel11: assert property (p_sel11) else $error("source 11 select wrong");

   property p_serial;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !trigger_kind_select_q[0] && trigger_polarity_select_q[0])
         |=> (interrupt_pending_q[0] == $past(serial_wire_idle_in));
   endproperty
   a_serial: assert property (p_serial) else $error("serial idle request wrong");

   property p_edge_fall;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && trigger_kind_select_q[1] && !trigger_polarity_select_q[1] && prev_src_q[1]
         && !raw_src[1]) |=> interrupt_pending_q[1];
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

   property p_pend_read;
      @(posedge clk_in) disable iff (rst_in)
      (rd_pend_q && addr_q == VECIRQ_OFS_PENDING)
         |-> (hrdata_out == {16'h0000, $past(interrupt_pending_q)});
   endproperty
   a_pend_read: assert property (p_pend_read) else $error("pending readback wrong");

   property p_masked;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && interrupt_enable_mask_q == 16'h0000) |=> !cpu_interrupt_request_out;
   endproperty
   a_masked: assert property (p_masked) else $error("masked request raised line");

   property p_okay;
      @(posedge clk_in) disable iff (rst_in)
      hreadyout_out && !hresp_out;
   endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");

   property p_rdata_idle;
      @(posedge clk_in) disable iff (rst_in)
      !rd_pend_q |-> (hrdata_out == 32'h0000_0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");
endmodule : vecirq_unit

/* vecirq_unit_tb.sv */
/*
 vecirq_unit_tb: self-checking bench for the interrupt unit.
 assumes: hreadyout is fed back as hready; sources are driven at edges.
*/
`timescale 1ns/10ps
module vecirq_unit_tb;
   import vecirq_pkg::*;
   localparam int SETTLE = 8; // two-cycle path plus pin sync, with margin
   logic clk_in, rst_in, hready, hwrite, irq, gie, taken, resp;
   logic [1:0] htrans;
   logic [2:0] hsize, alt;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0] vec, tvec;
   logic [15:0] src, pol, en, p;
   logic [7:0] ofs [6];
   int seed = 31297;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;

   vecirq_unit vecirq_unit_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(resp), .serial_wire_idle_in(src[0]),
      .tick_in(src[2]), .timer_in(src[3]), .uart_in(src[5]), .codec_tx_in(src[6]),
      .codec_rx_in(src[7]), .codec_err_in(src[8]), .printer_motor_in(src[10]),
      .scanner_motor_in(alt[0]), .dma2_in(src[11]), .dma3_in(src[12]),
      .scanner_in(alt[1]), .dma0_in(src[13]), .printer_in(alt[2]), .dma1_in(src[14]),
      .external_request_a_in(src[1]), .external_request_b_in(src[4]),
      .external_request_c_in(src[9]), .external_request_d_in(src[15]),
      .cpu_interrupt_request_out(irq), .interrupt_vector_out(vec));
   vecirq_cpu_model vecirq_cpu_model_inst (.clk_in(clk_in), .rst_in(rst_in),
      .gie_in(gie), .irq_in(irq), .vector_in(vec), .taken_out(taken),
      .taken_vec_out(tvec));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   function automatic logic [7:0] exp_vec(input logic [15:0] act);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (act[i]) idx = 4'(i);
      end
      return {4'h2, idx};
   endfunction : exp_vec

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s %h/%h", $time, m, seen, exp);
      end
   endtask : check

   // single word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      haddr <= {24'h0, a};
      htrans <= VECIRQ_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk_in); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic settle(input logic [15:0] v);
      @(posedge clk_in);
      src <= v;
      repeat (SETTLE) @(posedge clk_in);
   endtask : settle

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      rst_in = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = VECIRQ_HSIZE_WORD;
      hwdata = 32'h0;
      src = 16'h0;
      alt = 3'h0;
      gie = 1'b0;
      ofs = '{VECIRQ_OFS_ENABLE, VECIRQ_OFS_ECLR, VECIRQ_OFS_KIND, VECIRQ_OFS_POL,
         VECIRQ_OFS_SEL, 8'h1c};
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ofs[i], 32'h0);
         check(r, 32'h0, "reset or unmapped read");
         check({31'h0, resp}, 32'h0, "okay response");
      end
      bus(1'b1, 8'h1c, 32'hffff_ffff);
      bus(1'b0, 8'h1c, 32'h0);
      check(r, 32'h0, "unmapped write");
      $display("reset test done");
      // level mode, random polarity, mask and sources
      for (int i = 0; i < 24; i++) begin
         pol = 16'($random(seed));
         en = (i == 0) ? 16'h0 : (i == 1) ? 16'h0001 : 16'($random(seed));
         bus(1'b1, VECIRQ_OFS_KIND, 32'h0);
         bus(1'b1, VECIRQ_OFS_POL, {16'h0, pol});
         bus(1'b1, VECIRQ_OFS_ENABLE, {16'h0, en});
         settle((i == 1) ? ~pol : 16'($random(seed)));
         p = ~(src ^ pol);
         bus(1'b1, VECIRQ_OFS_PENDING, 32'h0);
         bus(1'b0, VECIRQ_OFS_PENDING, 32'h0);
         check(r, {16'h0, p}, "pending");
         bus(1'b0, VECIRQ_OFS_ENABLE, 32'h0);
         check(r, {16'h0, en}, "enable readback");
         bus(1'b0, VECIRQ_OFS_VECTOR, 32'h0);
         check(r, {24'h0, exp_vec(p & en)}, "vector register");
         check({31'h0, irq}, {31'h0, |(p & en)}, "irq line");
         check({24'h0, vec}, {24'h0, exp_vec(p & en)}, "vector pins");
      end
      $display("level test done");
      // edges: 3 rising, 2 falling
      bus(1'b1, VECIRQ_OFS_ENABLE, 32'h0);
      settle(16'h0004);
      bus(1'b1, VECIRQ_OFS_KIND, 32'h0000_7c0c);
      bus(1'b1, VECIRQ_OFS_POL, 32'h0000_7ded);
      bus(1'b1, VECIRQ_OFS_ECLR, 32'h0000_ffff);
      settle(16'h000c);
      settle(16'h0004);
      bus(1'b0, VECIRQ_OFS_PENDING, 32'h0);
      check(r & 32'h0c, 32'h08, "rising edge latched");
      bus(1'b1, VECIRQ_OFS_ECLR, 32'h0000_0004);
      settle(16'h0001);
      bus(1'b0, VECIRQ_OFS_PENDING, 32'h0);
      check(r & 32'h0c, 32'h08, "falling edge ignored under rising polarity");
      bus(1'b1, VECIRQ_OFS_ECLR, 32'h0000_0009);
      bus(1'b0, VECIRQ_OFS_PENDING, 32'h0);
      check(r & 32'h0d, 32'h01, "edge clear, level kept");
      $display("edge test done");
      // source selection for 11, 13, 14
      bus(1'b1, VECIRQ_OFS_KIND, 32'h0);
      bus(1'b1, VECIRQ_OFS_POL, 32'h0000_ffff);
      @(posedge clk_in);
      alt <= 3'h7;
      for (int s = 0; s < 8; s++) begin
         bus(1'b1, VECIRQ_OFS_SEL, 32'(s));
         settle(16'h0000);
         bus(1'b0, VECIRQ_OFS_PENDING, 32'h0);
         check(r & 32'h6800, {17'h0, s[2], s[1], 1'b0, s[0], 11'h0}, "select");
      end
      $display("select test done");
      // cpu takes the highest enabled request: external pin c over uart
      bus(1'b1, VECIRQ_OFS_SEL, 32'h0);
      bus(1'b1, VECIRQ_OFS_ENABLE, 32'h0000_ffff);
      settle(16'h0220);
      @(posedge clk_in);
      gie <= 1'b1;
      for (int k = 0; k < 20 && taken !== 1'b1; k++) @(posedge clk_in);
      check({31'h0, taken}, 32'h1, "cpu took request");
      check({24'h0, tvec}, 32'h29, "taken vector");
      @(posedge clk_in);
      gie <= 1'b0;
      bus(1'b1, VECIRQ_OFS_ENABLE, 32'h0000_0020);
      repeat (SETTLE) @(posedge clk_in);
      check({24'h0, vec}, 32'h25, "nested mask");
      $display("cpu test done");
      summarize();
   end
endmodule : vecirq_unit_tb
